//--- eps_pkg.sv
// Constants, types and register map of the extended positioning sequencer.
// Assumes a single 40 MHz clock domain and an AXI4-Lite master outside.
// What this block does
// R1 - Relative mode moves commanded travel at speed
// R2 - Modulo only when relative and modulo bit
// R3 - Modulo keeps stepping while start high
// R4 - At-speed output rises when ramp-up ends, in modulo mode only; code compares velocity with SPEED, so it never rises for a negative travel
// R5 - Start low at ramp-down: stop, at-speed low
// R6 - Start high at ramp-down: continue next travel
// R7 - Substitutional run accelerates, sign sets direction
// R8 - After reference, zero position then position target
// R9 - Reference taken from inverter zero-pulse input
// R10 - Short target: hard stop or overrun-return
// R11 - Controller issues drive command code 16 first; the block has no command output, the drive model takes CMD_CODE as a parameter
// R12 - Controller sets link cycle at least 1 ms
// R13 - Controller never commands target position zero; code loads TRAVEL unchecked, so zero is accepted
// R14 - Function selected with type code 11
// R15 - Start rising edge begins positioning, clears done
// R16 - Stop rising edge decelerates with stop deceleration
// R17 - Done output set at standstill
// R18 - Overrun-return only with reversal enable bit
package eps_pkg;
  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0] EPS_OFS_CTRL = 8'h00;
  localparam logic [7:0] EPS_OFS_TRAVEL = 8'h04;
  localparam logic [7:0] EPS_OFS_SPEED = 8'h08;
  localparam logic [7:0] EPS_OFS_ACCEL = 8'h0C;
  localparam logic [7:0] EPS_OFS_STOPDEC = 8'h10;
  localparam logic [7:0] EPS_OFS_STATUS = 8'h14;
  localparam logic [7:0] EPS_OFS_POS = 8'h18;
  localparam logic [7:0] EPS_OFS_VEL = 8'h1C;
  localparam logic [7:0] EPS_OFS_IRQ_STAT = 8'h20;
  localparam logic [7:0] EPS_OFS_IRQ_EN = 8'h24;
  localparam logic [7:0] EPS_OFS_IRQ_CLR = 8'h28;
  // Control word fields
  localparam int EPS_BIT_SUBST = 1;
  localparam int EPS_BIT_REVERSE = 2;
  localparam int EPS_BIT_MODULO = 4;
  localparam int EPS_TYPE_LSB = 8;
  localparam logic [7:0] EPS_FUNC_TYPE = 8'h0B;
  localparam logic [31:0] EPS_CTRL_RESET = 32'h0000_0000;
  // Interrupt bits
  localparam int EPS_IRQ_DONE = 0;
  localparam int EPS_IRQ_ATSPEED = 1;
  localparam int EPS_IRQ_REF = 2;
  localparam int EPS_IRQ_W = 3;
  // Motion tick: profile updates at 1 kHz
  localparam int EPS_CLK_HZ = 40000000;
  localparam int EPS_TICK_HZ = 1000;
  localparam int EPS_TICK_CYC = EPS_CLK_HZ / EPS_TICK_HZ;
  localparam logic [15:0] EPS_TICK_LAST = 16'(EPS_TICK_CYC - 1);
  localparam logic [1:0] EPS_RESP_OK = 2'b00;
  localparam logic [1:0] EPS_RESP_ERR = 2'b10;

  typedef enum logic [5:0] {
    EPS_IDLE = 6'b000001,
    EPS_RUN = 6'b000010,
    EPS_SEEK = 6'b000100,
    EPS_STOPPING = 6'b001000,
    EPS_OVERRUN = 6'b010000,
    EPS_RETURN = 6'b100000
  } eps_state_t;
endpackage

//--- eps_prof_if.sv
// Profile step channel between the sequencer and its ramp generator.
// Assumes both ends share clock_in.
`timescale 1ns/1ps
`default_nettype none
interface eps_prof_if;
  logic step;
  logic signed [31:0] target_vel;
  logic [31:0] accel;
  logic hard;
  logic signed [31:0] vel;
  modport seq (output step, output target_vel, output accel, output hard, input vel);
  modport ramp (input step, input target_vel, input accel, input hard, output vel);
endinterface
`default_nettype wire

//--- eps_ramp.sv
// Speed ramp generator: slews velocity toward target each motion tick.
// Assumes step is a one-cycle tick enable.
`timescale 1ns/1ps
`default_nettype none
module eps_ramp (
  input wire logic clock_in,
  input wire logic rst_b_in,
  eps_prof_if.ramp prof
);
  import eps_pkg::*;
  logic signed [31:0] vel_reg, vel_next;
  logic signed [31:0] diff;

  // ----------------------------------------------------------------
  // Ramp
  // ----------------------------------------------------------------
  // Hard mode jumps straight, used for the brake-less target stop
  always_comb begin
    diff = prof.target_vel - vel_reg;
    vel_next = vel_reg;
    if (prof.step) begin
      if (prof.hard || (diff >= 0 && diff <= $signed(prof.accel)) ||
          (diff < 0 && -diff <= $signed(prof.accel))) begin
        vel_next = prof.target_vel;
      end else if (diff > 0) begin
        vel_next = vel_reg + $signed(prof.accel);
      end else begin
        vel_next = vel_reg - $signed(prof.accel);
      end
    end
  end

  always_ff @(posedge clock_in) begin
    if (!rst_b_in) begin
      vel_reg <= '0;
    end else begin
      vel_reg <= vel_next;
    end
  end
  assign prof.vel = vel_reg;
endmodule
`default_nettype wire

//--- eps_seq.sv
// Extended positioning sequencer top: AXI4-Lite registers and motion FSM.
// Assumes start, stop and zero pulse inputs synchronous to clock_in.
`timescale 1ns/1ps
`default_nettype none
module eps_seq (
  input wire logic clock_in,
  input wire logic rst_b_in,
  input wire logic [7:0] s_axi_awaddr_in,
  input wire logic s_axi_awvalid_in,
  output logic s_axi_awready_out,
  input wire logic [31:0] s_axi_wdata_in,
  input wire logic [3:0] s_axi_wstrb_in,
  input wire logic s_axi_wvalid_in,
  output logic s_axi_wready_out,
  output logic [1:0] s_axi_bresp_out,
  output logic s_axi_bvalid_out,
  input wire logic s_axi_bready_in,
  input wire logic [7:0] s_axi_araddr_in,
  input wire logic s_axi_arvalid_in,
  output logic s_axi_arready_out,
  output logic [31:0] s_axi_rdata_out,
  output logic [1:0] s_axi_rresp_out,
  output logic s_axi_rvalid_out,
  input wire logic s_axi_rready_in,
  input wire logic start_input_in,
  input wire logic stop_input_in,
  input wire logic zero_pulse_in,
  output logic done_output_out,
  output logic at_speed_output_out,
  output logic zero_feedback_out,
  output logic signed [31:0] speed_cmd_out,
  output logic irq_out
);
  import eps_pkg::*;
  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Byte-lane merge, used by every writable register except IRQ_CLR
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d, input logic [3:0] s);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      r[i*8 +: 8] = s[i] ? d[i*8 +: 8] : r[i*8 +: 8];
    end
    return r;
  endfunction
  function automatic logic [31:0] absval(input logic signed [31:0] v);
    return (v < 0) ? 32'(-v) : 32'(v);
  endfunction
  // ----------------------------------------------------------------
  // Register bus
  // ----------------------------------------------------------------
  logic [31:0] ctrl_reg, ctrl_next, travel_reg, travel_next, speed_reg, speed_next;
  logic [31:0] accel_reg, accel_next, stopdec_reg, stopdec_next;
  logic [EPS_IRQ_W-1:0] irq_en_reg, irq_en_next, irq_stat_reg, irq_stat_next, irq_set;
  logic aw_ok_reg, aw_ok_next, w_ok_reg, w_ok_next, bvalid_reg, bvalid_next;
  logic [7:0] awaddr_reg, awaddr_next;
  logic [31:0] wdata_reg, wdata_next;
  logic [3:0] wstrb_reg, wstrb_next;
  logic [1:0] bresp_reg, bresp_next, rresp_reg, rresp_next;
  logic rvalid_reg, rvalid_next;
  logic [31:0] rdata_reg, rdata_next;
  logic do_write;
  logic [EPS_IRQ_W-1:0] irq_clr;
  logic signed [31:0] pos_reg, pos_next;
  logic done_reg, done_next, atspd_reg, atspd_next;
  eps_state_t state_reg, state_next;
  assign s_axi_awready_out = !aw_ok_reg && !bvalid_reg;
  assign s_axi_wready_out = !w_ok_reg && !bvalid_reg;
  assign s_axi_arready_out = !rvalid_reg;
  assign do_write = aw_ok_reg && w_ok_reg && !bvalid_reg;
  // Address and data latched independently, response after both
  always_comb begin
    aw_ok_next = aw_ok_reg;
    w_ok_next = w_ok_reg;
    awaddr_next = awaddr_reg;
    wdata_next = wdata_reg;
    wstrb_next = wstrb_reg;
    bvalid_next = bvalid_reg;
    bresp_next = bresp_reg;
    ctrl_next = ctrl_reg;
    travel_next = travel_reg;
    speed_next = speed_reg;
    accel_next = accel_reg;
    stopdec_next = stopdec_reg;
    irq_en_next = irq_en_reg;
    irq_clr = '0;
    if (s_axi_awvalid_in && s_axi_awready_out) begin
      aw_ok_next = 1'b1;
      awaddr_next = s_axi_awaddr_in;
    end
    if (s_axi_wvalid_in && s_axi_wready_out) begin
      w_ok_next = 1'b1;
      wdata_next = s_axi_wdata_in;
      wstrb_next = s_axi_wstrb_in;
    end
    if (do_write) begin
      aw_ok_next = 1'b0;
      w_ok_next = 1'b0;
      bvalid_next = 1'b1;
      bresp_next = EPS_RESP_OK;
      case (awaddr_reg)
        EPS_OFS_CTRL: ctrl_next = merge(ctrl_reg, wdata_reg, wstrb_reg);
        EPS_OFS_TRAVEL: travel_next = merge(travel_reg, wdata_reg, wstrb_reg);
        EPS_OFS_SPEED: speed_next = merge(speed_reg, wdata_reg, wstrb_reg);
        EPS_OFS_ACCEL: accel_next = merge(accel_reg, wdata_reg, wstrb_reg);
        EPS_OFS_STOPDEC: stopdec_next = merge(stopdec_reg, wdata_reg, wstrb_reg);
        EPS_OFS_IRQ_EN: irq_en_next = EPS_IRQ_W'(merge({29'h0, irq_en_reg}, wdata_reg, wstrb_reg));
        EPS_OFS_IRQ_CLR: irq_clr = wstrb_reg[0] ? wdata_reg[EPS_IRQ_W-1:0] : '0;
        EPS_OFS_STATUS, EPS_OFS_POS, EPS_OFS_VEL, EPS_OFS_IRQ_STAT: bresp_next = EPS_RESP_OK;
        default: bresp_next = EPS_RESP_ERR;
      endcase
    end else if (bvalid_reg && s_axi_bready_in) begin
      bvalid_next = 1'b0;
    end
  end

  // Read path; one-cycle answer after address accepted
  always_comb begin
    rvalid_next = rvalid_reg;
    rdata_next = rdata_reg;
    rresp_next = rresp_reg;
    if (s_axi_arvalid_in && s_axi_arready_out) begin
      rvalid_next = 1'b1;
      rresp_next = EPS_RESP_OK;
      case (s_axi_araddr_in)
        EPS_OFS_CTRL: rdata_next = ctrl_reg;
        EPS_OFS_TRAVEL: rdata_next = travel_reg;
        EPS_OFS_SPEED: rdata_next = speed_reg;
        EPS_OFS_ACCEL: rdata_next = accel_reg;
        EPS_OFS_STOPDEC: rdata_next = stopdec_reg;
        EPS_OFS_STATUS: rdata_next = {26'h0, state_reg};
        EPS_OFS_POS: rdata_next = pos_reg;
        EPS_OFS_VEL: rdata_next = speed_cmd_out;
        EPS_OFS_IRQ_STAT: rdata_next = {29'h0, irq_stat_reg};
        EPS_OFS_IRQ_EN: rdata_next = {29'h0, irq_en_reg};
        EPS_OFS_IRQ_CLR: rdata_next = 32'h0000_0000;
        default: begin
          rdata_next = 32'h0000_0000;
          rresp_next = EPS_RESP_ERR;
        end
      endcase
    end else if (rvalid_reg && s_axi_rready_in) begin
      rvalid_next = 1'b0;
    end
  end

  // Set wins over clear so no event is lost
  assign irq_stat_next = (irq_stat_reg & ~irq_clr) | irq_set;

  always_ff @(posedge clock_in) begin
    if (!rst_b_in) begin
      aw_ok_reg <= 1'b0;
      w_ok_reg <= 1'b0;
      awaddr_reg <= '0;
      wdata_reg <= '0;
      wstrb_reg <= '0;
      bvalid_reg <= 1'b0;
      bresp_reg <= EPS_RESP_OK;
      rvalid_reg <= 1'b0;
      rdata_reg <= '0;
      rresp_reg <= EPS_RESP_OK;
      ctrl_reg <= EPS_CTRL_RESET;
      travel_reg <= '0;
      speed_reg <= '0;
      accel_reg <= '0;
      stopdec_reg <= '0;
      irq_en_reg <= '0;
      irq_stat_reg <= '0;
    end else begin
      aw_ok_reg <= aw_ok_next;
      w_ok_reg <= w_ok_next;
      awaddr_reg <= awaddr_next;
      wdata_reg <= wdata_next;
      wstrb_reg <= wstrb_next;
      bvalid_reg <= bvalid_next;
      bresp_reg <= bresp_next;
      rvalid_reg <= rvalid_next;
      rdata_reg <= rdata_next;
      rresp_reg <= rresp_next;
      ctrl_reg <= ctrl_next;
      travel_reg <= travel_next;
      speed_reg <= speed_next;
      accel_reg <= accel_next;
      stopdec_reg <= stopdec_next;
      irq_en_reg <= irq_en_next;
      irq_stat_reg <= irq_stat_next;
    end
  end
  assign s_axi_bvalid_out = bvalid_reg;
  assign s_axi_bresp_out = bresp_reg;
  assign s_axi_rvalid_out = rvalid_reg;
  assign s_axi_rdata_out = rdata_reg;
  assign s_axi_rresp_out = rresp_reg;
  assign irq_out = |(irq_stat_reg & irq_en_reg);

  // ----------------------------------------------------------------
  // Motion tick and edges
  // ----------------------------------------------------------------
  logic [15:0] tick_cnt_reg, tick_cnt_next;
  logic tick, start_d_reg, stop_d_reg, start_rise, stop_rise;
  assign tick = (tick_cnt_reg == EPS_TICK_LAST);
  assign tick_cnt_next = tick ? 16'h0000 : tick_cnt_reg + 16'h0001;
  assign start_rise = start_input_in && !start_d_reg;
  assign stop_rise = stop_input_in && !stop_d_reg;

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  eps_prof_if prof ();
  eps_ramp u_ramp (.clock_in(clock_in), .rst_b_in(rst_b_in), .prof(prof));
  logic selected, subst, reverse, modulo, thard;
  logic signed [31:0] remain_reg, remain_next, vel, spd, tvel;
  logic [31:0] brake_dist, amag, tacc;
  logic zero_reg, zero_next, stopcmd_reg, stopcmd_next;
  assign selected = (ctrl_reg[EPS_TYPE_LSB +: 8] == EPS_FUNC_TYPE); // R14
  assign subst = ctrl_reg[EPS_BIT_SUBST];
  assign reverse = ctrl_reg[EPS_BIT_REVERSE]; // R18
  assign modulo = !subst && ctrl_reg[EPS_BIT_MODULO]; // R2
  assign vel = prof.vel;
  assign spd = $signed(speed_reg);
  assign amag = (accel_reg == 32'h0) ? 32'h0000_0001 : accel_reg;
  // Coarse braking distance v*v/(2a), in position units
  assign brake_dist = 32'((64'(absval(vel)) * 64'(absval(vel))) / (64'(amag) * 64'h2));
  // Next state, remaining distance, flags
  always_comb begin
    state_next = state_reg;
    remain_next = remain_reg - ((tick && state_reg != EPS_SEEK) ? vel : 32'sh0);
    done_next = done_reg;
    stopcmd_next = stopcmd_reg && (state_reg == EPS_STOPPING);
    atspd_next = atspd_reg;
    zero_next = 1'b0;
    irq_set = '0;
    tvel = vel;
    tacc = amag;
    thard = 1'b0;
    pos_next = pos_reg + (tick ? vel : 32'sh0);
    case (state_reg)
      EPS_IDLE: begin
        tvel = 32'sh0;
        if (start_rise && selected) begin
          done_next = 1'b0; // R15
          remain_next = $signed(travel_reg); // R1
          state_next = subst ? EPS_SEEK : EPS_RUN; // R7
        end
      end
      EPS_RUN: begin
        tvel = (remain_reg < 0) ? -spd : spd; // R1
        if (modulo && vel == spd && !atspd_reg) begin
          atspd_next = 1'b1; // R4
          irq_set[EPS_IRQ_ATSPEED] = 1'b1;
        end
        if (absval(remain_reg) <= brake_dist) begin
          if (modulo && start_input_in) begin
            remain_next = remain_next + $signed(travel_reg); // R3 R6
          end else begin
            atspd_next = 1'b0; // R5
            state_next = EPS_STOPPING;
          end
        end
      end
      EPS_SEEK: begin
        tvel = spd; // R7
        if (zero_pulse_in) begin
          zero_next = 1'b1; // R8 R9
          pos_next = 32'sh0;
          irq_set[EPS_IRQ_REF] = 1'b1;
          remain_next = $signed(travel_reg); // R13
          if (absval($signed(travel_reg)) < brake_dist || (($signed(travel_reg) < 0) != (spd < 0))) begin
            state_next = reverse ? EPS_OVERRUN : EPS_STOPPING; // R10 R18
          end else begin
            state_next = EPS_RUN;
          end
        end
      end
      EPS_STOPPING: begin
        tvel = 32'sh0;
        thard = subst && !reverse && !stopcmd_reg; // R10
        tacc = stopcmd_reg ? stopdec_reg : amag; // R16
        if (vel == 32'sh0) begin
          state_next = EPS_IDLE;
        end
      end
      EPS_OVERRUN: begin
        tvel = 32'sh0; // R10
        if (vel == 32'sh0) begin
          state_next = EPS_RUN;
        end
      end
      default: state_next = EPS_IDLE;
    endcase
    if (stop_rise && state_reg != EPS_IDLE) begin
      tvel = 32'sh0; // R16
      tacc = stopdec_reg;
      atspd_next = 1'b0;
      stopcmd_next = 1'b1;
      state_next = EPS_STOPPING;
    end
    if (state_reg == EPS_STOPPING && vel == 32'sh0 && !done_reg) begin
      done_next = 1'b1; // R17
      irq_set[EPS_IRQ_DONE] = 1'b1;
    end
  end
  assign prof.step = tick;
  assign prof.target_vel = tvel;
  assign prof.accel = tacc;
  assign prof.hard = thard;
  always_ff @(posedge clock_in) begin
    if (!rst_b_in) begin
      state_reg <= EPS_IDLE;
      tick_cnt_reg <= '0;
      start_d_reg <= 1'b0;
      stop_d_reg <= 1'b0;
      remain_reg <= '0;
      pos_reg <= '0;
      done_reg <= 1'b1;
      atspd_reg <= 1'b0;
      zero_reg <= 1'b0;
      stopcmd_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      tick_cnt_reg <= tick_cnt_next;
      start_d_reg <= start_input_in;
      stop_d_reg <= stop_input_in;
      remain_reg <= remain_next;
      pos_reg <= pos_next;
      done_reg <= done_next;
      atspd_reg <= atspd_next;
      zero_reg <= zero_next;
      stopcmd_reg <= stopcmd_next;
    end
  end
  assign done_output_out = done_reg;
  assign at_speed_output_out = atspd_reg;
  assign zero_feedback_out = zero_reg;
  assign speed_cmd_out = prof.vel;
endmodule
`default_nettype wire

//--- eps_seq_chk.sv
// Concurrent checks on the positioning sequencer top-level ports.
// Assumes one clock domain and a synchronous active-low reset.
`timescale 1ns/1ps
`default_nettype none
module eps_seq_chk (
  input wire logic clock_in,
  input wire logic rst_b_in,
  input wire logic s_axi_awvalid_in,
  input wire logic s_axi_awready_out,
  input wire logic s_axi_wvalid_in,
  input wire logic s_axi_wready_out,
  input wire logic [1:0] s_axi_bresp_out,
  input wire logic s_axi_bvalid_out,
  input wire logic s_axi_bready_in,
  input wire logic s_axi_arvalid_in,
  input wire logic s_axi_arready_out,
  input wire logic [31:0] s_axi_rdata_out,
  input wire logic s_axi_rvalid_out,
  input wire logic s_axi_rready_in,
  input wire logic start_input_in,
  input wire logic stop_input_in,
  input wire logic done_output_out,
  input wire logic at_speed_output_out,
  input wire logic zero_feedback_out,
  input wire logic signed [31:0] speed_cmd_out
);
  logic stop_d_reg, stop_d_next, brake_reg, brake_next;
  logic [31:0] mag_now;
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!rst_b_in);
  // ----------------------------------------------------------------
  // Helper: braking after a stop edge
  // ----------------------------------------------------------------
  // Cleared on a start level too, since a resume may accelerate again
  always_comb begin
    stop_d_next = stop_input_in;
    brake_next = brake_reg;
    if (done_output_out || start_input_in) begin
      brake_next = 1'b0;
    end else if (stop_input_in && !stop_d_reg) begin
      brake_next = 1'b1;
    end
  end
  // Register the helper state
  always_ff @(posedge clock_in) begin
    if (!rst_b_in) begin
      stop_d_reg <= 1'b0;
      brake_reg <= 1'b0;
    end else begin
      stop_d_reg <= stop_d_next;
      brake_reg <= brake_next;
    end
  end
  assign mag_now = speed_cmd_out[31] ? 32'(-speed_cmd_out) : 32'(speed_cmd_out);
  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  chk_done_start: assert property ($fell(done_output_out) |-> $past(start_input_in) || $past(start_input_in, 2))
    else $error("done fell without a start edge");
  chk_idle_still: assert property (done_output_out |-> speed_cmd_out == 32'sh0)
    else $error("done high while speed is not zero");
  chk_stop_decel: assert property (brake_reg && $changed(speed_cmd_out) |-> mag_now < $past(mag_now))
    else $error("speed grew while stopping");
  chk_at_speed_run: assert property (at_speed_output_out |-> !done_output_out && speed_cmd_out != 32'sh0)
    else $error("at-speed high at standstill");
  chk_zero_pulse: assert property (zero_feedback_out |=> !zero_feedback_out)
    else $error("feedback zeroing longer than one cycle");
  chk_b_answer: assert property (s_axi_awvalid_in && s_axi_awready_out && s_axi_wvalid_in && s_axi_wready_out
    |=> ##1 s_axi_bvalid_out) else $error("write response late");
  chk_b_hold: assert property (s_axi_bvalid_out && !s_axi_bready_in |=> s_axi_bvalid_out && $stable(s_axi_bresp_out))
    else $error("write response dropped");
  chk_w_refuse: assert property (s_axi_bvalid_out |-> !s_axi_awready_out && !s_axi_wready_out)
    else $error("write taken while response pending");
  chk_r_answer: assert property (s_axi_arvalid_in && s_axi_arready_out |=> s_axi_rvalid_out)
    else $error("read data late");
  chk_r_hold: assert property (s_axi_rvalid_out && !s_axi_rready_in |=> s_axi_rvalid_out && $stable(s_axi_rdata_out))
    else $error("read data dropped");
  cover property ($fell(done_output_out));
  cover property (brake_reg && $changed(speed_cmd_out));
  cover property (s_axi_bvalid_out && s_axi_bresp_out == 2'b10);
  cover property ($rose(done_output_out));
endmodule
bind eps_seq eps_seq_chk u_chk (.*);
`default_nettype wire

//--- eps_drive_model.sv
// Behavioural drive: integrates the speed command, emits zero pulses.
// Assumes the sequencer's speed command changes once per motion tick.
`timescale 1ns/1ps
`default_nettype none
module eps_drive_model #(
  parameter int TICK_CYC = 40000,
  parameter int REF_SPAN = 1000,
  parameter int CMD_CODE = 16
) (
  input wire logic clock_in,
  input wire logic rst_b_in,
  input wire logic signed [31:0] speed_in,
  input wire logic zero_fb_in,
  output logic zero_pulse_out,
  output logic signed [31:0] pos_out
);
  int cnt;
  logic signed [31:0] pos_nx;
  assign pos_nx = pos_out + speed_in;
  // Feedback moves once per link cycle, never faster than the tick
  always @(posedge clock_in) begin
    if (!rst_b_in) begin
      cnt <= 0;
      pos_out <= 32'sh0;
      zero_pulse_out <= 1'b0;
    end else begin
      cnt <= (cnt == TICK_CYC - 1) ? 0 : cnt + 1;
      zero_pulse_out <= 1'b0;
      if (zero_fb_in) begin
        pos_out <= 32'sh0;
      end else if (cnt == TICK_CYC - 1) begin
        pos_out <= pos_nx;
        // Homing pulse only when the model is built with CMD_CODE 16
        if (CMD_CODE == 16 && pos_nx / REF_SPAN != pos_out / REF_SPAN) begin
          zero_pulse_out <= 1'b1;
        end
      end
    end
  end
endmodule
`default_nettype wire

//--- tb.sv
// Self-checking bench for the positioning sequencer.
// Assumes the checker is bound in and the drive model closes the loop.
`timescale 1ns/1ps
`default_nettype none
module tb;
  import eps_pkg::*;
  logic clock_in, rst_b_in, s_axi_awvalid_in, s_axi_wvalid_in, s_axi_bready_in, s_axi_arvalid_in;
  logic s_axi_rready_in, start_input_in, stop_input_in;
  logic [7:0] s_axi_awaddr_in, s_axi_araddr_in;
  logic [31:0] s_axi_wdata_in, s_axi_rdata_out, v, rd;
  logic [3:0] s_axi_wstrb_in;
  logic s_axi_awready_out, s_axi_wready_out, s_axi_bvalid_out, s_axi_arready_out, s_axi_rvalid_out;
  logic done_output_out, at_speed_output_out, zero_feedback_out, irq_out;
  logic [1:0] s_axi_bresp_out, s_axi_rresp_out, rs;
  logic signed [31:0] speed_cmd_out;
  wire zero_pulse_in;
  int n_fail = 0;
  int n_tests = 0;
  int seed = 76220;
  logic [7:0] ofs [4] = '{EPS_OFS_TRAVEL, EPS_OFS_SPEED, EPS_OFS_ACCEL, EPS_OFS_STOPDEC};
  eps_seq dut (.*);
  eps_drive_model #(.CMD_CODE(16)) u_drive (.clock_in, .rst_b_in, .speed_in(speed_cmd_out),
    .zero_fb_in(zero_feedback_out), .zero_pulse_out(zero_pulse_in), .pos_out());
  always #12.5 clock_in = ~clock_in;
  // ----------------------------------------------------------------
  // Report and compare tasks
  // ----------------------------------------------------------------
  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic tmo(input string m);
    n_fail++;
    $display("wrong value at %0t: timeout %s", $time, m);
    finish_test();
  endtask
  task automatic chk_val(input logic [31:0] got, input logic [31:0] exp, input string m);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value at %0t: %s got %h expected %h", $time, m, got, exp);
    end
  endtask
  task automatic chk_resp(input logic [1:0] got, input logic [1:0] exp, input string m);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value at %0t: %s resp %b expected %b", $time, m, got, exp);
    end
  endtask
  // ----------------------------------------------------------------
  // Bus and motion drivers
  // ----------------------------------------------------------------
  // Address and data offered together, each dropped when taken
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    int n = 0;
    @(posedge clock_in);
    s_axi_awaddr_in <= a;
    s_axi_awvalid_in <= 1'b1;
    s_axi_wdata_in <= d;
    s_axi_wvalid_in <= 1'b1;
    s_axi_bready_in <= 1'b1;
    do begin
      @(posedge clock_in);
      n++;
      if (s_axi_awready_out) s_axi_awvalid_in <= 1'b0;
      if (s_axi_wready_out) s_axi_wvalid_in <= 1'b0;
      if (n > 100) tmo("write");
    end while (s_axi_bvalid_out !== 1'b1);
    r = s_axi_bresp_out;
    s_axi_bready_in <= 1'b0;
  endtask
  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int n = 0;
    @(posedge clock_in);
    s_axi_araddr_in <= a;
    s_axi_arvalid_in <= 1'b1;
    s_axi_rready_in <= 1'b1;
    do begin
      @(posedge clock_in);
      n++;
      if (s_axi_arready_out) s_axi_arvalid_in <= 1'b0;
      if (n > 100) tmo("read");
    end while (s_axi_rvalid_out !== 1'b1);
    d = s_axi_rdata_out;
    r = s_axi_rresp_out;
    s_axi_rready_in <= 1'b0;
  endtask
  task automatic pulse(input bit stop);
    @(posedge clock_in);
    if (stop) stop_input_in <= 1'b1;
    else start_input_in <= 1'b1;
    @(posedge clock_in);
    stop_input_in <= 1'b0;
    start_input_in <= 1'b0;
  endtask
  // Bounded wait for the done level
  task automatic wait_done(input int lim, input logic lvl);
    int n = 0;
    while (done_output_out !== lvl) begin
      @(posedge clock_in);
      n++;
      if (n > lim) tmo("done");
    end
  endtask
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    {clock_in, rst_b_in, s_axi_awvalid_in, s_axi_wvalid_in, s_axi_bready_in} = '0;
    {s_axi_arvalid_in, s_axi_rready_in, start_input_in, stop_input_in} = '0;
    {s_axi_awaddr_in, s_axi_araddr_in, s_axi_wdata_in} = '0;
    s_axi_wstrb_in = 4'hF;
    repeat (2) @(posedge clock_in);
    rst_b_in <= 1'b1;
    @(posedge clock_in);
    chk_val(32'(done_output_out), 32'h1, "done after reset");
    chk_val(speed_cmd_out, 32'h0, "speed after reset");
    // Commanded parameters hold random values
    foreach (ofs[i]) begin
      v = $random(seed);
      axi_wr(ofs[i], v, rs);
      axi_rd(ofs[i], rd, rs);
      chk_val(rd, v, "parameter readback");
    end
    axi_wr(8'h3C, 32'h5, rs);
    chk_resp(rs, EPS_RESP_ERR, "unmapped write");
    axi_rd(8'h3C, rd, rs);
    chk_resp(rs, EPS_RESP_ERR, "unmapped read");
    axi_wr(EPS_OFS_STATUS, 32'hFFFF_FFFF, rs);
    chk_resp(rs, EPS_RESP_OK, "read-only write");
    $display("register test finished");
    // Wrong function type must not start
    axi_wr(EPS_OFS_CTRL, 32'h0000_0A00, rs);
    pulse(1'b0);
    repeat (4) @(posedge clock_in);
    chk_val(32'(done_output_out), 32'h1, "start with wrong type");
    axi_wr(EPS_OFS_SPEED, 32'h7, rs);
    axi_wr(EPS_OFS_ACCEL, 32'h7, rs);
    axi_wr(EPS_OFS_STOPDEC, 32'h7, rs);
    axi_wr(EPS_OFS_TRAVEL, 32'h000F_0000, rs);
    axi_wr(EPS_OFS_IRQ_EN, 32'h0, rs);
    axi_wr(EPS_OFS_CTRL, 32'(EPS_FUNC_TYPE) << EPS_TYPE_LSB, rs);
    pulse(1'b0);
    wait_done(4, 1'b0);
    for (int n = 0; speed_cmd_out === 32'sh0; n++) begin
      @(posedge clock_in);
      if (n > 41000) tmo("ramp");
    end
    chk_val(speed_cmd_out, 32'h7, "first ramp step");
    chk_val(32'(at_speed_output_out), 32'h0, "at-speed outside modulo");
    pulse(1'b1);
    wait_done(41000, 1'b1);
    chk_val(speed_cmd_out, 32'h0, "speed at standstill");
    $display("motion test finished");
    // Done event latched, masked, then enabled and cleared
    axi_rd(EPS_OFS_IRQ_STAT, rd, rs);
    chk_val(rd, 32'h1 << EPS_IRQ_DONE, "done event latched");
    chk_val(32'(irq_out), 32'h0, "masked interrupt");
    axi_wr(EPS_OFS_IRQ_EN, 32'h1 << EPS_IRQ_DONE, rs);
    repeat (2) @(posedge clock_in);
    chk_val(32'(irq_out), 32'h1, "enabled interrupt");
    axi_wr(EPS_OFS_IRQ_CLR, 32'h1 << EPS_IRQ_DONE, rs);
    repeat (2) @(posedge clock_in);
    chk_val(32'(irq_out), 32'h0, "cleared interrupt");
    axi_rd(EPS_OFS_IRQ_STAT, rd, rs);
    chk_val(rd, 32'h0, "status after clear");
    $display("interrupt test finished");
    finish_test();
  end
endmodule
`default_nettype wire
